// *** src/phy_pm_consts.vh ***
// constants for the power-mode controller and pin-chain test block
`ifndef PHY_PM_CONSTS_VH
`define PHY_PM_CONSTS_VH
// register indices (byte address = 4 * index)
`define REG_BASIC_CTRL     8'h00
`define REG_PHY_CTRL1      8'h10
`define REG_AFE_CTRL       8'h11
`define REG_DIAG_CTRL      8'h16
`define REG_EXP_CTRL       8'h18
`define REG_PHY_CTRL2      8'h1f
`define REG_LINK_STATE     8'h20
`define REG_POWER_STATUS   8'h21
// field positions
`define BIT_SOFT_RESET     15
`define BIT_AUTONEG_EN     12
`define BIT_POWER_DOWN     11
`define BIT_PLL_AUTO_OFF   4
`define BIT_SLOW_OSC       5
`define BIT_CHAIN_TEST     5
`define BIT_SLEEP_DISABLE  11
`define BIT_POWER_SAVE     10
// reset values
`define RST_BASIC_CTRL     16'h1000
`define RST_PHY_CTRL1      16'h0000
`define RST_AFE_CTRL       16'h0000
`define RST_DIAG_CTRL      16'h0000
`define RST_EXP_CTRL       16'h0800
`define RST_PHY_CTRL2      16'h0000
// timing
// counts at the 50 ns clock: 1000 ns soft reset, 16 us link pulse period
`define SOFT_RESET_CYC     16'h0014
`define PULSE_PERIOD_CYC   16'h0140
`define PULSE_STRETCH      3'h4
`endif

// *** src/phy_power_modes.v ***
// power-mode control, soft reset and pin-chain test with an apb register slave
`timescale 1ns/1ps
`include "phy_pm_consts.vh"

// Function
// [RQ1] software computes fault distance as nine-bit result times a calibratable constant
// [RQ2] in chain test, all digital inputs feed a nested nand chain onto txd1
// [RQ3] software enters chain test by setting bit 5 of register 16h
// [RQ4] chain order mdio, mdc, rxd1, rxd0, crs_dv, ref_clk, irq, txen, status_indicator_output_0, txd0
// [RQ5] test logic drives all inputs high, then pulls each low in order
// [RQ6] each successive input pulled low toggles the chain output, first high-to-low
// [RQ7] test logic flags an input faulty when pulling it low gives no toggle
// [RQ8] bit 10 of 1fh enables power saving while autoneg on and no link
// [RQ9] power saving is off after power-up
// [RQ10] clearing bit 11 of 18h enables energy-detect sleep; default disabled
// [RQ11] bit 4 of 10h also turns pll off during energy-detect sleep
// [RQ12] during energy-detect sleep link pulses keep being sent periodically
// [RQ13] bit 11 of 0h powers down all but management; clearing exits
// [RQ14] bit 5 of 11h switches the device onto the on-chip slow oscillator
// [RQ15] slow oscillator with power-down gives lowest power, management alive
// [RQ16] exit: clear slow-osc, clear power-down, then write soft reset bit
// [RQ17] soft reset bit clears itself when the reset completes
module phy_power_modes (
    input  wire        clk_i,              // 20 mhz system clock
    input  wire        rst_i,              // asynchronous reset, active high
    input  wire        psel_i,             // apb select
    input  wire        penable_i,          // apb enable
    input  wire        pwrite_i,           // apb direction, 1 = write
    input  wire [31:0] paddr_i,            // apb byte address
    input  wire [31:0] pwdata_i,           // apb write data
    output reg  [31:0] prdata_o,           // apb read data
    output reg         pready_o,           // apb ready
    output reg         pslverr_o,          // apb error on unmapped address
    input  wire        link_up_i,          // link present, same clock domain
    input  wire        energy_i,           // energy detected on cable, same domain
    input  wire [9:0]  chain_pins_i,       // chain pins in chain order, bit 0 first
    output reg         txd1_o,             // txd1 pin level (chain result in test)
    output reg         chain_mode_o,       // pin-chain test active
    output reg         save_blocks_off_o,  // receive blocks off in power saving
    output reg         sleep_o,            // energy-detect sleep in effect
    output reg         pll_off_o,          // pll switched off
    output reg         core_off_o,         // all but management powered down
    output reg         slow_osc_o,         // running on the on-chip slow oscillator
    output reg         link_pulse_o,       // link pulse request during sleep
    output reg         soft_reset_o        // internal soft reset in progress
);
    // one-hot soft reset states
    localparam [1:0] ST_IDLE  = 2'b01;
    localparam [1:0] ST_RESET = 2'b10;
    localparam [15:0] RESET_CYC = `SOFT_RESET_CYC;
    localparam [15:0] PULSE_CYC = `PULSE_PERIOD_CYC;

    wire [15:0] basic_ctrl;
    wire [15:0] phy_ctrl1;
    wire [15:0] afe_ctrl;
    wire [15:0] diag_ctrl;
    wire [15:0] exp_ctrl;
    wire [15:0] phy_ctrl2;
    reg [1:0]  state;
    reg [15:0] reset_cnt;
    reg [15:0] pulse_cnt;
    reg [2:0]  pulse_hold;
    reg [9:0]  pins_meta;
    reg [9:0]  pins_sync;
    reg [15:0] read_mux;
    reg        addr_hit;
    reg        chain_out;
    integer    k;

    wire [7:0] reg_index = paddr_i[9:2];
    wire       aligned   = (paddr_i[1:0] == 2'b00) && (paddr_i[31:10] == 22'h000000);
    wire       access    = psel_i && penable_i && !pready_o;
    // writes land on the edge that completes the transfer, address still standing
    wire       complete  = psel_i && penable_i && pready_o;
    wire       wr_en     = complete && pwrite_i && addr_hit;
    // a soft reset in progress swallows writes; the bus still gets its answer
    wire       bus_load  = wr_en && (state == ST_IDLE);
    wire       restore   = (state == ST_RESET) && (reset_cnt == 16'h0001);
    wire       load_basic = bus_load && (reg_index == `REG_BASIC_CTRL);
    wire       load_phy1  = bus_load && (reg_index == `REG_PHY_CTRL1);
    wire       load_afe   = bus_load && (reg_index == `REG_AFE_CTRL);
    wire       load_diag  = bus_load && (reg_index == `REG_DIAG_CTRL);
    wire       load_exp   = bus_load && (reg_index == `REG_EXP_CTRL);
    wire       load_phy2  = bus_load && (reg_index == `REG_PHY_CTRL2);
    wire       idle_link = basic_ctrl[`BIT_AUTONEG_EN] && !link_up_i;
    wire       save_on   = phy_ctrl2[`BIT_POWER_SAVE] && idle_link;             // RQ8
    wire       sleep_on  = !exp_ctrl[`BIT_SLEEP_DISABLE] && idle_link && !energy_i; // RQ10

    // register decode and read view
    always @* begin
        addr_hit = aligned;
        read_mux = 16'h0000;
        case (reg_index)
            `REG_BASIC_CTRL:   read_mux = basic_ctrl;
            `REG_PHY_CTRL1:    read_mux = phy_ctrl1;
            `REG_AFE_CTRL:     read_mux = afe_ctrl;
            `REG_DIAG_CTRL:    read_mux = diag_ctrl;
            `REG_EXP_CTRL:     read_mux = exp_ctrl;
            `REG_PHY_CTRL2:    read_mux = phy_ctrl2;
            `REG_LINK_STATE:   read_mux = {14'h0000, energy_i, link_up_i};
            `REG_POWER_STATUS: read_mux = {8'h00, soft_reset_o, link_pulse_o, slow_osc_o,
                                           core_off_o, pll_off_o, sleep_o,
                                           save_blocks_off_o, chain_mode_o};
            default:           addr_hit = 1'b0;
        endcase
        if (!aligned) begin
            addr_hit = 1'b0;
        end
    end

    // nested nand chain over the synchronised pins, first pin innermost
    always @* begin
        chain_out = 1'b1;
        for (k = 0; k < 10; k = k + 1) begin
            chain_out = ~(chain_out & pins_sync[k]); // RQ2
        end
    end

    // apb slave, one wait state: ready one cycle after the access phase begins
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
        end else begin
            pready_o  <= access;
            pslverr_o <= access && !addr_hit;
            if (access && !pwrite_i) begin
                prdata_o <= addr_hit ? {16'h0000, read_mux} : 32'h00000000;
            end
        end
    end

    // control words; the end of a soft reset puts every one back to its default
    // so the reset bit in the basic word clears itself
    ctrl_word #(
        .RESET_VALUE (`RST_BASIC_CTRL)
    ) i_ctrl_word_basic (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .restore_i (restore),        // RQ17
        .load_i    (load_basic),     // RQ13
        .data_i    (pwdata_i[15:0]),
        .value_o   (basic_ctrl)
    );

    ctrl_word #(
        .RESET_VALUE (`RST_PHY_CTRL1)
    ) i_ctrl_word_phy1 (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .restore_i (restore),
        .load_i    (load_phy1),      // RQ11
        .data_i    (pwdata_i[15:0]),
        .value_o   (phy_ctrl1)
    );

    ctrl_word #(
        .RESET_VALUE (`RST_AFE_CTRL)
    ) i_ctrl_word_afe (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .restore_i (restore),
        .load_i    (load_afe),       // RQ14
        .data_i    (pwdata_i[15:0]),
        .value_o   (afe_ctrl)
    );

    ctrl_word #(
        .RESET_VALUE (`RST_DIAG_CTRL)
    ) i_ctrl_word_diag (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .restore_i (restore),
        .load_i    (load_diag),      // RQ3
        .data_i    (pwdata_i[15:0]),
        .value_o   (diag_ctrl)
    );

    // sleep disable bit set at power-up
    ctrl_word #(
        .RESET_VALUE (`RST_EXP_CTRL) // RQ10
    ) i_ctrl_word_exp (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .restore_i (restore),
        .load_i    (load_exp),
        .data_i    (pwdata_i[15:0]),
        .value_o   (exp_ctrl)
    );

    // power saving off at power-up
    ctrl_word #(
        .RESET_VALUE (`RST_PHY_CTRL2) // RQ9
    ) i_ctrl_word_phy2 (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .restore_i (restore),
        .load_i    (load_phy2),      // RQ8
        .data_i    (pwdata_i[15:0]),
        .value_o   (phy_ctrl2)
    );

    // soft reset sequencer; writes during the reset are dropped
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state     <= ST_IDLE;
            reset_cnt <= 16'h0000;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (basic_ctrl[`BIT_SOFT_RESET]) begin
                        state     <= ST_RESET;
                        reset_cnt <= RESET_CYC; // RQ16
                    end
                end
                ST_RESET: begin
                    reset_cnt <= reset_cnt - 16'h0001;
                    if (reset_cnt == 16'h0001) begin
                        state <= ST_IDLE; // RQ17
                    end
                end
                default: begin
                    state     <= ST_IDLE;
                    reset_cnt <= 16'h0000;
                end
            endcase
        end
    end

    // chain pins come from the board, so two flops before the nand chain
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pins_meta <= 10'h000;
            pins_sync <= 10'h000;
        end else begin
            pins_meta <= chain_pins_i;
            pins_sync <= pins_meta; // RQ4
        end
    end

    // periodic link pulse while asleep; slow oscillator would stretch it in silicon
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pulse_cnt  <= 16'h0000;
            pulse_hold <= 3'h0;
        end else if (!sleep_on) begin
            pulse_cnt  <= 16'h0000;
            pulse_hold <= 3'h0;
        end else if (pulse_cnt == PULSE_CYC - 16'h0001) begin
            pulse_cnt  <= 16'h0000;
            pulse_hold <= `PULSE_STRETCH; // RQ12
        end else begin
            pulse_cnt <= pulse_cnt + 16'h0001;
            if (pulse_hold != 3'h0) begin
                pulse_hold <= pulse_hold - 3'h1;
            end
        end
    end

    // registered outputs
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            txd1_o            <= 1'b0;
            chain_mode_o      <= 1'b0;
            save_blocks_off_o <= 1'b0;
            sleep_o           <= 1'b0;
            pll_off_o         <= 1'b0;
            core_off_o        <= 1'b0;
            slow_osc_o        <= 1'b0;
            link_pulse_o      <= 1'b0;
            soft_reset_o      <= 1'b0;
        end else begin
            chain_mode_o      <= diag_ctrl[`BIT_CHAIN_TEST];
            txd1_o            <= diag_ctrl[`BIT_CHAIN_TEST] ? chain_out : 1'b0; // RQ6
            save_blocks_off_o <= save_on || sleep_on || basic_ctrl[`BIT_POWER_DOWN];
            sleep_o           <= sleep_on;
            pll_off_o         <= (sleep_on && phy_ctrl1[`BIT_PLL_AUTO_OFF]) ||
                                 basic_ctrl[`BIT_POWER_DOWN]; // RQ11
            core_off_o        <= basic_ctrl[`BIT_POWER_DOWN]; // RQ13
            slow_osc_o        <= afe_ctrl[`BIT_SLOW_OSC];     // RQ14 RQ15
            link_pulse_o      <= sleep_on && (pulse_hold != 3'h0); // RQ12
            soft_reset_o      <= (state == ST_RESET);
        end
    end
endmodule // phy_power_modes

// one control word: takes a bus write, falls back to its default on any reset
module ctrl_word #(
    parameter [15:0] RESET_VALUE = 16'h0000 // contents after any reset
) (
    input  wire        clk_i,     // system clock
    input  wire        rst_i,     // asynchronous reset, active high
    input  wire        restore_i, // end of soft reset, back to default
    input  wire        load_i,    // bus write to this word
    input  wire [15:0] data_i,    // write data
    output reg  [15:0] value_o    // current contents
);
    // the restore outranks a bus write landing in the same cycle
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            value_o <= RESET_VALUE;
        end else if (restore_i) begin
            value_o <= RESET_VALUE;
        end else if (load_i) begin
            value_o <= data_i;
        end
    end
endmodule // ctrl_word

// *** testbench/phy_power_modes_chk.sv ***
// port-level assertions for the power-mode and pin-chain block
`timescale 1ns/1ps
module phy_power_modes_chk (
    input wire logic       clk_i,              // clock
    input wire logic       rst_i,              // reset
    input wire logic       psel_i,             // apb select
    input wire logic       penable_i,          // apb enable
    input wire logic       pready_o,           // apb ready
    input wire logic       pslverr_o,          // apb error
    input wire logic       link_up_i,          // link present
    input wire logic       energy_i,           // cable energy
    input wire logic [9:0] chain_pins_i,       // chain pins
    input wire logic       txd1_o,             // chain output
    input wire logic       chain_mode_o,       // chain test on
    input wire logic       save_blocks_off_o,  // power saving
    input wire logic       sleep_o,            // energy-detect sleep
    input wire logic       pll_off_o,          // pll off
    input wire logic       core_off_o,         // power-down
    input wire logic       link_pulse_o        // link pulse
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // first pin sits deepest in the nest
    function automatic logic chain(input logic [9:0] p);
        logic x;
        x = 1'b1;
        for (int i = 0; i < 10; i++) x = ~(x & p[i]);
        return x;
    endfunction
    sequence s_pulse;
        link_pulse_o [*4] ##1 !link_pulse_o;
    endsequence
    sequence s_next;
        ##[318:322] ($rose(link_pulse_o) || !sleep_o);
    endsequence
    a_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o && !$past(pready_o))
        else $error("ready not one cycle after access");
    a_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_chain_out: assert property (chain_mode_o && $past(chain_mode_o, 2) |->
        txd1_o == chain($past(chain_pins_i, 3))) else $error("chain output wrong");
    a_txd1_idle: assert property (!chain_mode_o && !$past(chain_mode_o) |-> !txd1_o)
        else $error("txd1 active outside chain test");
    a_save_link: assert property (save_blocks_off_o && !core_off_o |-> !$past(link_up_i))
        else $error("power saving with link");
    a_sleep_cause: assert property (sleep_o |-> !$past(link_up_i) && !$past(energy_i))
        else $error("sleep with link or energy");
    a_pll_cause: assert property (pll_off_o |-> sleep_o || core_off_o)
        else $error("pll off while awake");
    a_core_blocks: assert property (core_off_o |-> pll_off_o && save_blocks_off_o)
        else $error("power-down left blocks on");
    a_pulse_len: assert property ($rose(link_pulse_o) |-> sleep_o ##0 s_pulse)
        else $error("link pulse shape wrong");
    a_pulse_period: assert property ($rose(link_pulse_o) |-> s_next)
        else $error("link pulse period wrong");
endmodule // phy_power_modes_chk
bind phy_power_modes phy_power_modes_chk i_phy_power_modes_chk (.clk_i, .rst_i, .psel_i,
    .penable_i, .pready_o, .pslverr_o, .link_up_i, .energy_i, .chain_pins_i, .txd1_o,
    .chain_mode_o, .save_blocks_off_o, .sleep_o, .pll_off_o, .core_off_o, .link_pulse_o);

// *** testbench/chain_board.sv ***
// board test logic model driving the pin chain
`timescale 1ns/1ps
module chain_board (
    input  wire logic [3:0] low_count_i,  // pins pulled low, in chain order
    output logic      [9:0] pins_o        // chain pin levels
);
    always_comb begin
        for (int i = 0; i < 10; i++) pins_o[i] = (i >= low_count_i) ? 1'b1 : 1'b0;
    end
endmodule // chain_board

// *** testbench/tb_phy_power_modes_and_io_chain_test.sv ***
// self-checking bench for the power-mode and pin-chain block
`timescale 1ns/1ps
`include "phy_pm_consts.vh"
module tb_phy_power_modes_and_io_chain_test;
    typedef struct packed {logic wr; logic [7:0] idx; logic [15:0] d; logic [15:0] e;} row_t;
    logic clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic link_up_i = 1'b0, energy_i = 1'b0, pready_o, pslverr_o, txd1_o, chain_mode_o;
    logic save_blocks_off_o, sleep_o, pll_off_o, core_off_o, slow_osc_o, link_pulse_o;
    logic soft_reset_o, err, last;
    logic [31:0] paddr_i = 32'h0, pwdata_i = 32'h0, prdata_o, rd;
    logic [9:0] chain_pins_i;
    logic [3:0] low_count = 4'h0;
    int mismatches = 0, num_checks = 0, n, r;
    row_t rows [14] = '{
        '{0, 8'h00, 16'h0, 16'h1000}, '{0, 8'h18, 16'h0, 16'h0800}, '{0, 8'h1f, 16'h0, 16'h0},
        '{0, 8'h21, 16'h0, 16'h0}, '{1, 8'h1f, 16'h0400, 16'h0}, '{0, 8'h21, 16'h0, 16'h0002},
        '{1, 8'h1f, 16'h0, 16'h0}, '{1, 8'h11, 16'h0020, 16'h0}, '{0, 8'h21, 16'h0, 16'h0020},
        '{1, 8'h00, 16'h1800, 16'h0}, '{0, 8'h21, 16'h0, 16'h003a}, '{1, 8'h11, 16'h0, 16'h0},
        '{1, 8'h00, 16'h1000, 16'h0}, '{0, 8'h21, 16'h0, 16'h0}};
    always #25 clk_i = ~clk_i;
    phy_power_modes i_phy_power_modes (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .link_up_i(link_up_i), .energy_i(energy_i), .chain_pins_i(chain_pins_i),
        .txd1_o(txd1_o), .chain_mode_o(chain_mode_o), .save_blocks_off_o(save_blocks_off_o),
        .sleep_o(sleep_o), .pll_off_o(pll_off_o), .core_off_o(core_off_o),
        .slow_osc_o(slow_osc_o), .link_pulse_o(link_pulse_o), .soft_reset_o(soft_reset_o));
    chain_board i_chain_board (.low_count_i(low_count), .pins_o(chain_pins_i));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // software side: nine-bit diagnostic field to fault distance in centimetres
    function automatic int fault_cm(input logic [8:0] field);
        return field * 38;
    endfunction
    // register index to byte address; idle cycle kept between transfers
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] d);
        int k;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= {22'h0, idx, 2'b00};
        pwdata_i <= {16'h0, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        k = 0;
        do @(posedge clk_i); while (pready_o !== 1'b1 && ++k < 50);
        if (k >= 50) mismatches++;
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #(20000 * 50);
        mismatches++;
        close_out;
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].idx, rows[i].d);
            if (!rows[i].wr) chk(rd, {16'h0, rows[i].e});
        end
        apb(0, 8'h05, 16'h0);
        chk({rd[0], err}, 2'b01);
        apb(1, `REG_DIAG_CTRL, 16'h0020);
        repeat (2) @(posedge clk_i);
        chk(chain_mode_o, 1'b1);
        for (int k = 0; k <= 10; k++) begin
            low_count <= k[3:0];
            repeat (5) @(posedge clk_i);
            chk(txd1_o, k % 2 == 0);
        end
        apb(1, `REG_DIAG_CTRL, 16'h0);
        low_count <= 4'h0;
        apb(1, `REG_EXP_CTRL, 16'h0);
        apb(1, `REG_PHY_CTRL1, 16'h0010);
        repeat (3) @(posedge clk_i);
        chk({sleep_o, pll_off_o}, 2'b11);
        r = 0;
        last = 1'b0;
        for (n = 0; n < 700; n++) begin
            @(posedge clk_i);
            if (link_pulse_o && !last) r++;
            last = link_pulse_o;
        end
        chk(r, 2);
        link_up_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(sleep_o, 1'b0);
        apb(1, `REG_PHY_CTRL2, 16'h0400);
        apb(1, `REG_BASIC_CTRL, 16'h9000);
        repeat (3) @(posedge clk_i);
        chk(soft_reset_o, 1'b1);
        n = 0;
        // bounded wait: soft reset ends on its own
        do @(posedge clk_i); while ((soft_reset_o !== 1'b0 || n < 4) && ++n < 100);
        if (n >= 100) mismatches++;
        apb(0, `REG_BASIC_CTRL, 16'h0);
        chk(rd, 32'h1000);
        apb(0, `REG_PHY_CTRL2, 16'h0);
        chk(rd, 32'h0);
        // mid-run reset brings the power-up defaults back
        apb(1, `REG_PHY_CTRL2, 16'h0400);
        apb(1, `REG_EXP_CTRL, 16'h0);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        apb(0, `REG_PHY_CTRL2, 16'h0);
        chk(rd, 32'h0);
        apb(0, `REG_EXP_CTRL, 16'h0);
        chk(rd, 32'h0800);
        chk(fault_cm(9'h1ff), 32'h00004bda);
        close_out;
    end
endmodule // tb_phy_power_modes_and_io_chain_test
